// ---- vpe_far_side.sv ----
// Far-side model: redistributor config acceptance and interrupt discard
`timescale 1ns/100ps
`default_nettype none
module vpe_far_side (
    // Clock, reset and answer wait
    input wire logic i_clock,
    input wire logic i_reset,
    input wire logic [3:0] i_delay,
    // Requests and answers
    input wire logic i_cfg_write,
    input wire logic i_discard_req,
    output logic o_cfg_ack,
    output logic o_discard_done
);
    logic [3:0] wait_reg;
    logic [4:0] disc_reg;
    // Ack a held write after the wait, count out a discard
    always @(posedge i_clock) begin
        if (i_reset) begin
            wait_reg <= 4'h0;
            disc_reg <= 5'h0;
            o_cfg_ack <= 1'b0;
            o_discard_done <= 1'b0;
        end else begin
            o_cfg_ack <= i_cfg_write && !o_cfg_ack && wait_reg == i_delay;
            wait_reg <= (i_cfg_write && wait_reg != i_delay) ? wait_reg + 4'h1 : 4'h0;
            if (i_discard_req)
                disc_reg <= {1'b0, i_delay} + 5'h1;
            else if (disc_reg != 5'h0)
                disc_reg <= disc_reg - 5'h1;
            o_discard_done <= disc_reg == 5'h1;
        end
    end
endmodule // vpe_far_side
`default_nettype wire

// ---- vpe_map_command_exec.v ----
// Map-vPE command decoder and executor
// Summary of operation
// - Recognise the map command by opcode 0x29 in doubleword 0 low byte.
// - A packet is 32 bytes, four 64-bit doublewords indexed 0 to 3.
// - Older layout: pending table base is the address field with 16 low zeros.
// - Store the width field, virtual_interrupt_id bits minus one, with the vPE entry.
// - Map valid clear removes the mapping and discards the vPE's interrupts.
// - vPE number beyond the configured count raises a command error.
// - Older layout: width field beyond the id width field raises a command error.
// - Newer layout, mapping: bad wakeup id other than 1023 errors 0x01_2906.
// - Write entry with valid and redistributor base, then advance read pointer.
// - Out-of-range vPE may also signal a system error when supported.
// - Newer layout: out-of-range width is used as given or replaced in 13..23.
// - Newer layout: config table address has sixteen zero low bits.
// - Newer layout forwards all configuration fields to the redistributors.
// - Zeroed flag ignored unless map valid and first-or-last are both set.
// - An unmap is not shown consumed until all its effects have completed.
`timescale 1ns/100ps
`default_nettype none
`include "vpe_map_defs.vh"

module vpe_map_command_exec (
    // Clock, reset, clock enable
    input wire i_clock,
    input wire i_reset,
    input wire i_enable,
    // Static configuration
    input wire i_newer_layout,
    input wire [`VPE_NUM_W:0] i_vpe_count,
    input wire [`WIDTH_W-1:0] i_id_width_field,
    input wire i_system_error_support,
    input wire [`WIDTH_W-1:0] i_lpi_width_minus_one,
    input wire i_substitute_width,
    // Command packet in
    input wire i_cmd_valid,
    input wire [`DW_WIDTH-1:0] i_cmd_dw0,
    input wire [`DW_WIDTH-1:0] i_cmd_dw1,
    input wire [`DW_WIDTH-1:0] i_cmd_dw2,
    input wire [`DW_WIDTH-1:0] i_cmd_dw3,
    output reg o_cmd_ready,
    // Command outcome
    output reg o_read_ptr_advance,
    output reg o_cmd_ignored,
    output reg o_cmd_error,
    output reg [`ERR_CODE_W-1:0] o_error_code,
    output reg o_system_error,
    // Interrupt discard on unmap
    output reg o_discard_req,
    output reg [`VPE_NUM_W-1:0] o_discard_vpe,
    input wire i_discard_done,
    // Redistributor configuration write
    output reg o_cfg_write,
    output reg [`VPE_NUM_W-1:0] o_cfg_vpe,
    output reg [`ADDR_W-1:0] o_cfg_redist_base,
    output reg [`FULL_ADDR_W-1:0] o_cfg_config_addr,
    output reg [`FULL_ADDR_W-1:0] o_cfg_pending_addr,
    output reg [`WAKEUP_W-1:0] o_cfg_wakeup_id,
    output reg [`WIDTH_W-1:0] o_cfg_width,
    output reg o_cfg_map_valid,
    output reg o_cfg_first_last,
    output reg o_cfg_zeroed,
    input wire i_cfg_ack,
    // Table lookup
    input wire [`TABLE_IDX_W-1:0] i_lookup_index,
    output wire [`ENTRY_W-1:0] o_lookup_entry
);

    localparam S_IDLE = 3'd0;
    localparam S_CHECK = 3'd1;
    localparam S_CFG = 3'd2;
    localparam S_DISCARD = 3'd3;
    localparam S_DONE = 3'd4;

    reg [2:0] state_reg;
    reg [`DW_WIDTH-1:0] dw0_reg;
    reg [`DW_WIDTH-1:0] dw1_reg;
    reg [`DW_WIDTH-1:0] dw2_reg;
    reg [`DW_WIDTH-1:0] dw3_reg;
    reg table_write_reg;

    // Field extraction from the held packet
    wire [`VPE_NUM_W-1:0] vpe_num = dw1_reg[`VPE_NUM_HI:`VPE_NUM_LO];
    wire map_valid = dw2_reg[`MAP_VALID_BIT];
    wire [`ADDR_W-1:0] redist_base = dw2_reg[`ADDR_HI:`ADDR_LO];
    wire [`ADDR_W-1:0] pend_field = dw3_reg[`ADDR_HI:`ADDR_LO];
    wire [`ADDR_W-1:0] conf_field = dw0_reg[`ADDR_HI:`ADDR_LO];
    wire [`WIDTH_W-1:0] width_field = dw3_reg[`WIDTH_HI:`WIDTH_LO];
    wire [`WAKEUP_W-1:0] wakeup = dw1_reg[`WAKEUP_HI:`WAKEUP_LO];
    wire first_last = dw0_reg[`FIRST_LAST_BIT];
    wire zeroed_flag = dw0_reg[`ZEROED_BIT];

    // Range checks
    wire vpe_oor = ({1'b0, vpe_num} >= i_vpe_count) ||
        (vpe_num >= `TABLE_DEPTH);
    wire width_oor = width_field > i_id_width_field;
    wire [`WAKEUP_W-1:0] wakeup_shifted =
        wakeup >> ({1'b0, i_lpi_width_minus_one} + 6'h01);
    wire wakeup_oor = (wakeup != `WAKEUP_NONE) &&
        ((wakeup < `LPI_FIRST_ID) || (wakeup_shifted != 32'h0));

    // Width actually used in the newer layout
    wire [`WIDTH_W-1:0] width_used =
        (width_oor && i_substitute_width) ? `WIDTH_SUBST : width_field;

    // Pending table base with sixteen zero low bits
    wire [`FULL_ADDR_W-1:0] pend_base = {pend_field, {`ADDR_ZERO_BITS{1'b0}}};

    // Table entry: valid, redistributor base, pending base, width
    wire [`ENTRY_W-1:0] entry = i_newer_layout ?
        {map_valid, redist_base, pend_field, width_used} :
        {map_valid, redist_base, pend_field, width_field};

    vpe_table_mem u_table (
        .i_clock(i_clock),
        .i_enable(i_enable),
        .i_write(table_write_reg),
        .i_write_index(vpe_num[`TABLE_IDX_W-1:0]),
        .i_write_data(entry),
        .i_read_index(i_lookup_index),
        .o_read_data(o_lookup_entry)
    );

    // Command sequencing
    always @(posedge i_clock) begin
        if (i_reset) begin
            state_reg <= S_IDLE;
            dw0_reg <= 64'h0;
            dw1_reg <= 64'h0;
            dw2_reg <= 64'h0;
            dw3_reg <= 64'h0;
            table_write_reg <= 1'b0;
            o_cmd_ready <= 1'b1;
            o_read_ptr_advance <= 1'b0;
            o_cmd_ignored <= 1'b0;
            o_cmd_error <= 1'b0;
            o_error_code <= 24'h0;
            o_system_error <= 1'b0;
            o_discard_req <= 1'b0;
            o_discard_vpe <= 16'h0;
            o_cfg_write <= 1'b0;
            o_cfg_vpe <= 16'h0;
            o_cfg_redist_base <= 36'h0;
            o_cfg_config_addr <= 52'h0;
            o_cfg_pending_addr <= 52'h0;
            o_cfg_wakeup_id <= 32'h0;
            o_cfg_width <= 5'h0;
            o_cfg_map_valid <= 1'b0;
            o_cfg_first_last <= 1'b0;
            o_cfg_zeroed <= 1'b0;
        end else if (i_enable) begin
            // One-cycle pulses fall by default
            table_write_reg <= 1'b0;
            o_read_ptr_advance <= 1'b0;
            o_cmd_ignored <= 1'b0;
            o_cmd_error <= 1'b0;
            o_system_error <= 1'b0;
            o_discard_req <= 1'b0;
            case (state_reg)
                S_IDLE: begin
                    if (i_cmd_valid) begin
                        // Only the map opcode is taken
                        if (i_cmd_dw0[`OPCODE_HI:`OPCODE_LO] ==
                                `OPCODE_MAP_VPE) begin
                            dw0_reg <= i_cmd_dw0;
                            dw1_reg <= i_cmd_dw1;
                            dw2_reg <= i_cmd_dw2;
                            dw3_reg <= i_cmd_dw3;
                            o_cmd_ready <= 1'b0;
                            state_reg <= S_CHECK;
                        end else begin
                            o_cmd_ignored <= 1'b1;
                        end
                    end
                end
                S_CHECK: begin
                    if (vpe_oor) begin
                        o_cmd_error <= 1'b1;
                        o_error_code <= `ERR_VPE_RANGE;
                        o_system_error <= i_system_error_support;
                        o_cmd_ready <= 1'b1;
                        state_reg <= S_IDLE;
                    end else if (width_oor && !i_newer_layout) begin
                        o_cmd_error <= 1'b1;
                        o_error_code <= `ERR_WIDTH_RANGE;
                        o_cmd_ready <= 1'b1;
                        state_reg <= S_IDLE;
                    end else if (i_newer_layout && map_valid && wakeup_oor) begin
                        o_cmd_error <= 1'b1;
                        o_error_code <= `ERR_WAKEUP_RANGE;
                        o_cmd_ready <= 1'b1;
                        state_reg <= S_IDLE;
                    end else begin
                        table_write_reg <= 1'b1;
                        if (i_newer_layout) begin
                            // Forward configuration to redistributors
                            o_cfg_write <= 1'b1;
                            o_cfg_vpe <= vpe_num;
                            o_cfg_redist_base <= redist_base;
                            o_cfg_config_addr <=
                                {conf_field, {`ADDR_ZERO_BITS{1'b0}}};
                            o_cfg_pending_addr <= pend_base;
                            o_cfg_wakeup_id <= wakeup;
                            o_cfg_width <= width_used;
                            o_cfg_map_valid <= map_valid;
                            o_cfg_first_last <= first_last;
                            o_cfg_zeroed <=
                                zeroed_flag & map_valid & first_last;
                            state_reg <= S_CFG;
                        end else if (!map_valid) begin
                            o_discard_req <= 1'b1;
                            o_discard_vpe <= vpe_num;
                            state_reg <= S_DISCARD;
                        end else begin
                            state_reg <= S_DONE;
                        end
                    end
                end
                S_CFG: begin
                    // Hold the write until the redistributors accept it
                    if (i_cfg_ack) begin
                        o_cfg_write <= 1'b0;
                        if (!map_valid) begin
                            o_discard_req <= 1'b1;
                            o_discard_vpe <= vpe_num;
                            state_reg <= S_DISCARD;
                        end else begin
                            state_reg <= S_DONE;
                        end
                    end
                end
                S_DISCARD: begin
                    // Unmap completes before it is consumed
                    if (i_discard_done) begin
                        state_reg <= S_DONE;
                    end
                end
                S_DONE: begin
                    o_read_ptr_advance <= 1'b1;
                    o_cmd_ready <= 1'b1;
                    state_reg <= S_IDLE;
                end
                default: begin
                    o_cmd_ready <= 1'b1;
                    state_reg <= S_IDLE;
                end
            endcase
        end
    end

endmodule // vpe_map_command_exec
`default_nettype wire

// ---- vpe_map_command_exec_asserts.sv ----
// Port checks for the map-vPE command executor
`timescale 1ns/100ps
`default_nettype none
`include "vpe_map_defs.vh"
module vpe_map_command_exec_asserts (
    // Clock, reset and configuration
    input wire logic i_clock, i_reset, i_enable, i_newer_layout,
    input wire logic [`VPE_NUM_W:0] i_vpe_count,
    input wire logic [`WIDTH_W-1:0] i_id_width_field,
    input wire logic i_system_error_support,
    // Command and outcome
    input wire logic i_cmd_valid, o_cmd_ready, o_read_ptr_advance,
    input wire logic [`DW_WIDTH-1:0] i_cmd_dw0, i_cmd_dw1, i_cmd_dw2, i_cmd_dw3,
    input wire logic o_cmd_ignored, o_cmd_error, o_system_error,
    input wire logic [`ERR_CODE_W-1:0] o_error_code,
    // Discard and configuration write
    input wire logic o_discard_req, o_cfg_write, i_cfg_ack,
    input wire logic [`FULL_ADDR_W-1:0] o_cfg_config_addr, o_cfg_pending_addr,
    input wire logic o_cfg_zeroed, o_cfg_map_valid, o_cfg_first_last
);
    // Decode of the packet on offer
    wire taken = i_enable && o_cmd_ready && i_cmd_valid;
    wire is_map = i_cmd_dw0[7:0] == `OPCODE_MAP_VPE;
    wire vpe_bad = i_cmd_dw1[47:32] >= i_vpe_count || i_cmd_dw1[47:32] > 16'h00ff;
    wire width_bad = i_cmd_dw3[4:0] > i_id_width_field;
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_reset);
    sequence s_old_map;
        taken && is_map && !i_newer_layout && i_cmd_dw2[63] && !vpe_bad &&
            !width_bad;
    endsequence
    sequence s_consumed;
        o_read_ptr_advance && o_cmd_ready;
    endsequence
    ignore_other_a: assert property (taken && !is_map |=> o_cmd_ignored && o_cmd_ready) else $error("other opcode not ignored");
    vpe_range_a: assert property (taken && is_map && vpe_bad |-> ##2 o_cmd_error && o_error_code == `ERR_VPE_RANGE) else $error("vPE range error missing");
    width_range_a: assert property (taken && is_map && !i_newer_layout && !vpe_bad && width_bad |-> ##2 o_cmd_error && o_error_code == `ERR_WIDTH_RANGE) else $error("width error missing");
    sys_error_a: assert property (o_system_error |-> o_cmd_error && i_system_error_support && o_error_code == `ERR_VPE_RANGE) else $error("stray system error");
    old_map_done_a: assert property (s_old_map |-> ##1 !o_cmd_ready ##1 !o_read_ptr_advance ##1 s_consumed) else $error("map not consumed on time");
    unmap_hold_a: assert property (o_discard_req |-> !o_read_ptr_advance [*3]) else $error("unmap consumed too early");
    cfg_hold_a: assert property (o_cfg_write && !i_cfg_ack |=> o_cfg_write && $stable(o_cfg_pending_addr)) else $error("config write not held");
    addr_low_a: assert property (o_cfg_write |-> o_cfg_config_addr[15:0] == 16'h0 && o_cfg_pending_addr[15:0] == 16'h0) else $error("table address low bits set");
    zeroed_gate_a: assert property (o_cfg_write && o_cfg_zeroed |-> o_cfg_map_valid && o_cfg_first_last) else $error("zeroed flag not gated");
endmodule // vpe_map_command_exec_asserts
bind vpe_map_command_exec vpe_map_command_exec_asserts chk_i (.i_clock, .i_reset,
    .i_enable, .i_newer_layout, .i_vpe_count, .i_id_width_field,
    .i_system_error_support, .i_cmd_valid, .o_cmd_ready, .o_read_ptr_advance,
    .i_cmd_dw0, .i_cmd_dw1, .i_cmd_dw2, .i_cmd_dw3, .o_cmd_ignored, .o_cmd_error,
    .o_system_error, .o_error_code, .o_discard_req, .o_cfg_write, .i_cfg_ack,
    .o_cfg_config_addr, .o_cfg_pending_addr, .o_cfg_zeroed, .o_cfg_map_valid,
    .o_cfg_first_last);
`default_nettype wire

// ---- vpe_map_command_exec_tb.sv ----
// Self-checking bench for the map-vPE command executor
`timescale 1ns/100ps
`default_nettype none
`include "vpe_map_defs.vh"
module vpe_map_command_exec_tb;
    typedef struct {logic n, v; logic [15:0] p; logic [4:0] w; logic [31:0] k;
        logic [1:0] f; logic [7:0] op; logic [1:0] x; logic [23:0] c;} row_t;
    localparam logic [35:0] RDB = 36'h1_2345_6789;
    localparam logic [35:0] PT = 36'h0_abcd_ef01;
    localparam logic [35:0] CF = 36'h5_5555_aaaa;
    // Layout, valid, vPE, width, wakeup, zeroed/first, opcode, outcome, code
    row_t rows [11] = '{
        '{0, 1, 'h5, 'h4, 'h0, 'h0, 'h29, 'h0, 'h0},
        '{0, 0, 'h5, 'h4, 'h0, 'h0, 'h29, 'h0, 'h0},
        '{0, 1, 'h8, 'h4, 'h0, 'h0, 'h29, 'h1, 'h01_2901},
        '{1, 1, 'h9, 'h4, 'h3ff, 'h0, 'h29, 'h1, 'h01_2901},
        '{0, 1, 'h7, 'he, 'h0, 'h0, 'h29, 'h1, 'h01_2902},
        '{0, 1, 'h7, 'hd, 'h0, 'h0, 'h29, 'h0, 'h0},
        '{1, 1, 'h3, 'h14, 'h3ff, 'h1, 'h29, 'h0, 'h0},
        '{1, 1, 'h3, 'h8, 'h1fff, 'h0, 'h29, 'h1, 'h01_2906},
        '{1, 0, 'h3, 'h0, 'h0, 'h3, 'h29, 'h0, 'h0},
        '{1, 1, 'h4, 'h8, 'h2000, 'h3, 'h29, 'h0, 'h0},
        '{0, 1, 'h1, 'h0, 'h0, 'h0, 'h2a, 'h2, 'h0}};
    logic i_clock = '0, i_reset = 1'b1, i_enable = 1'b1, i_newer_layout = '0;
    logic [`VPE_NUM_W:0] i_vpe_count = 17'h8;
    logic [`WIDTH_W-1:0] i_id_width_field = 5'hd, i_lpi_width_minus_one = 5'hf;
    logic i_system_error_support = '0, i_substitute_width = '0, i_cmd_valid = '0;
    logic [`DW_WIDTH-1:0] i_cmd_dw0 = '0, i_cmd_dw1 = '0, i_cmd_dw2 = '0, i_cmd_dw3 = '0;
    logic [`TABLE_IDX_W-1:0] i_lookup_index = '0;
    logic [3:0] delay = '0;
    logic i_cfg_ack, i_discard_done, o_cmd_ready, o_read_ptr_advance, o_cmd_ignored;
    logic o_cmd_error, o_system_error, o_discard_req, o_cfg_write, o_cfg_map_valid;
    logic o_cfg_first_last, o_cfg_zeroed;
    logic [`ERR_CODE_W-1:0] o_error_code;
    logic [`VPE_NUM_W-1:0] o_discard_vpe, o_cfg_vpe;
    logic [`ADDR_W-1:0] o_cfg_redist_base;
    logic [`FULL_ADDR_W-1:0] o_cfg_config_addr, o_cfg_pending_addr;
    logic [`WAKEUP_W-1:0] o_cfg_wakeup_id;
    logic [`WIDTH_W-1:0] o_cfg_width;
    logic [`ENTRY_W-1:0] o_lookup_entry;
    logic [195:0] cfg_seen = '0;
    int err_total = 0, checks_done = 0, cycles = 0;
    vpe_map_command_exec dut (.i_clock, .i_reset, .i_enable, .i_newer_layout,
        .i_vpe_count, .i_id_width_field, .i_system_error_support,
        .i_lpi_width_minus_one, .i_substitute_width, .i_cmd_valid, .i_cmd_dw0,
        .i_cmd_dw1, .i_cmd_dw2, .i_cmd_dw3, .o_cmd_ready, .o_read_ptr_advance,
        .o_cmd_ignored, .o_cmd_error, .o_error_code, .o_system_error,
        .o_discard_req, .o_discard_vpe, .i_discard_done, .o_cfg_write, .o_cfg_vpe,
        .o_cfg_redist_base, .o_cfg_config_addr, .o_cfg_pending_addr,
        .o_cfg_wakeup_id, .o_cfg_width, .o_cfg_map_valid, .o_cfg_first_last,
        .o_cfg_zeroed, .i_cfg_ack, .i_lookup_index, .o_lookup_entry);
    vpe_far_side far (.i_clock, .i_reset, .i_delay(delay), .i_cfg_write(o_cfg_write),
        .i_discard_req(o_discard_req), .o_cfg_ack(i_cfg_ack),
        .o_discard_done(i_discard_done));
    // Clock and hang limit
    always #20 i_clock = ~i_clock;
    always @(posedge i_clock) begin
        cycles++;
        if (cycles == 20000) begin
            err_total++;
            report_and_stop();
        end
    end
    task chk(input string s, input logic [195:0] e, input logic [195:0] g);
        checks_done++;
        if (g !== e) begin
            $display("ERROR %s expected %h seen %h", s, e, g);
            err_total++;
        end
    endtask
    task report_and_stop;
        if (err_total == 0 && checks_done > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // Present one packet; unmap in the newer layout zeroes its address fields
    task drive(input row_t r);
        logic a;
        a = r.v || !r.n;
        i_newer_layout = r.n;
        i_system_error_support = r.p[0];
        i_cmd_dw0 = {12'h0, (r.n && r.v) ? CF : 36'h0, 6'h0, r.f, r.op};
        i_cmd_dw1 = {16'h0, r.p, r.k};
        i_cmd_dw2 = {r.v, 11'h0, a ? RDB : 36'h0, 16'h0};
        i_cmd_dw3 = {12'h0, a ? PT : 36'h0, 11'h0, r.w};
        i_cmd_valid = 1'b1;
    endtask
    // Run one row and compare its outcome
    task run(input int i);
        row_t r;
        logic [1:0] x;
        logic se;
        r = rows[i];
        x = 2'h3;
        se = 1'b0;
        delay = i[0] ? 4'h6 : 4'h0;
        drive(r);
        for (int n = 0; n < 60 && x == 2'h3; n++) begin
            @(negedge i_clock);
            i_cmd_valid = 1'b0;
            if (o_cfg_write === 1'b1 && i_cfg_ack === 1'b1)
                cfg_seen = {o_cfg_vpe, o_cfg_redist_base, o_cfg_config_addr,
                    o_cfg_pending_addr, o_cfg_wakeup_id, o_cfg_width,
                    o_cfg_map_valid, o_cfg_first_last, o_cfg_zeroed};
            if (o_discard_req === 1'b1)
                chk("discard_vpe", r.p, o_discard_vpe);
            if (o_read_ptr_advance === 1'b1) x = 2'h0;
            if (o_cmd_error === 1'b1) {x, se} = {2'h1, o_system_error};
            if (o_cmd_ignored === 1'b1) x = 2'h2;
        end
        chk("outcome", r.x, x);
        if (x == 2'h1) chk("code_sys", {r.c, r.c == `ERR_VPE_RANGE && r.p[0]}, {o_error_code, se});
        if (x == 2'h0 && r.n) chk("cfg", {r.p, r.v ? {RDB, CF, 16'h0, PT, 16'h0} : 140'h0, r.k, r.w, r.v, r.f[0], &{r.v, r.f}}, cfg_seen);
        if (x == 2'h0 && !r.n) begin
            i_lookup_index = r.p[7:0];
            @(negedge i_clock);
            if (r.v) chk("entry", {1'b1, RDB, PT, r.w}, o_lookup_entry);
            else chk("entry_valid", 1'b0, o_lookup_entry[77]);
        end
    endtask
    // Reset, table of rows, then reset during a waiting write
    initial begin
        repeat (3) @(negedge i_clock);
        i_reset = 1'b0;
        chk("reset_state", {1'b1, 26'h0}, {o_cmd_ready, o_error_code, o_cfg_write, o_read_ptr_advance});
        foreach (rows[i]) run(i);
        delay = 4'hf;
        drive(rows[9]);
        repeat (4) @(negedge i_clock) i_cmd_valid = 1'b0;
        chk("cfg_held", 1'b1, o_cfg_write);
        i_reset = 1'b1;
        @(negedge i_clock);
        i_reset = 1'b0;
        chk("cfg_dropped", 2'h1, {o_cfg_write, o_cmd_ready});
        run(0);
        report_and_stop();
    end
endmodule // vpe_map_command_exec_tb
`default_nettype wire

// ---- vpe_map_defs.vh ----
// Constants for the map-vPE command executor
`ifndef VPE_MAP_DEFS_VH
`define VPE_MAP_DEFS_VH

// Command packet layout
`define OPCODE_MAP_VPE 8'h29
`define PKT_DW_COUNT 4
`define PKT_BYTES 32
`define DW_WIDTH 64
`define OPCODE_HI 7
`define OPCODE_LO 0
`define VPE_NUM_HI 47
`define VPE_NUM_LO 32
`define ADDR_HI 51
`define ADDR_LO 16
`define ADDR_ZERO_BITS 16
`define MAP_VALID_BIT 63
`define WIDTH_HI 4
`define WIDTH_LO 0
`define ZEROED_BIT 9
`define FIRST_LAST_BIT 8
`define WAKEUP_HI 31
`define WAKEUP_LO 0

// Field widths
`define VPE_NUM_W 16
`define ADDR_W 36
`define FULL_ADDR_W 52
`define WIDTH_W 5
`define WAKEUP_W 32
`define ERR_CODE_W 24

// Per-vPE table
`define TABLE_IDX_W 8
`define TABLE_DEPTH 256
`define ENTRY_W 78

// Wakeup identifier values
`define WAKEUP_NONE 32'h0000_03ff
`define LPI_FIRST_ID 32'h0000_2000

// Replacement width used for an out-of-range width in the newer layout
`define WIDTH_SUBST 5'h10

// Command error codes
`define ERR_WAKEUP_RANGE 24'h01_2906
`define ERR_VPE_RANGE 24'h01_2901
`define ERR_WIDTH_RANGE 24'h01_2902

`endif

// ---- vpe_table_mem.v ----
// Per-vPE table memory with registered read data
`timescale 1ns/100ps
`default_nettype none
`include "vpe_map_defs.vh"

module vpe_table_mem (
    // Clock
    input wire i_clock,
    input wire i_enable,
    // Write port
    input wire i_write,
    input wire [`TABLE_IDX_W-1:0] i_write_index,
    input wire [`ENTRY_W-1:0] i_write_data,
    // Read port
    input wire [`TABLE_IDX_W-1:0] i_read_index,
    output reg [`ENTRY_W-1:0] o_read_data
);

    reg [`ENTRY_W-1:0] mem_reg [0:`TABLE_DEPTH-1];

    // Synchronous write, registered read
    always @(posedge i_clock) begin
        if (i_enable) begin
            if (i_write) begin
                mem_reg[i_write_index] <= i_write_data;
            end
            o_read_data <= mem_reg[i_read_index];
        end
    end

endmodule // vpe_table_mem
`default_nettype wire
